// [pkg/csdec_pkg.sv]
// constants, types and offsets of the chip select decoder
// assumes one 100 MHz clock and an 8-bit register port
// What this block does
// (RL1) Every bus cycle compares the bus address with each channel's start.
// (RL2) Each channel's mask register hides chosen address bits from compare.
// (RL3) An enabled channel that matches drives its select line low.
// (RL4) The start register is 8 bits holding compare values for A23..A16.
// (RL5) Compare values for A15..A8 are fixed zero with no storage.
// (RL6) Channel 0 always compares A23, A22 and A21.
// (RL7) Mask 1 ignores that address bit, mask 0 requires it equal the start.
// (RL8) Maskable ranges: ch0 A8-A20, ch1 A8-A21, ch2/3 A15-A22.
// (RL9) One mask bit covers A14..A9 together in ch0 and A15..A9 in ch1; bit 0 covers A8.
// (RL10) Start addresses fall on 64K-byte boundaries.
// (RL11) A start bit under a set mask bit acts as zero.
// (RL12) Mask bits need not be contiguous; gaps give split windows.
// (RL13) Software should set mask first, then start, then check overlaps.
// (RL14) Start/mask decode applies only while area source is 1.
// (RL15) Selects are high outside bus cycles; match is combinational.
package csdec_pkg;
    localparam int NUM_CH = 4;
    localparam int BUS_AW = 24;
    localparam logic [7:0] START0_OFS  = 8'h40;
    localparam logic [7:0] MASK0_OFS   = 8'h41;
    localparam logic [7:0] START1_OFS  = 8'h42;
    localparam logic [7:0] MASK1_OFS   = 8'h43;
    localparam logic [7:0] START2_OFS  = 8'h44;
    localparam logic [7:0] MASK2_OFS   = 8'h45;
    localparam logic [7:0] START3_OFS  = 8'h46;
    localparam logic [7:0] MASK3_OFS   = 8'h47;
    localparam logic [7:0] CTRL_OFS    = 8'h48;
    localparam logic [7:0] STATUS_OFS  = 8'h49;
    localparam logic [7:0] START_RST   = 8'hff;
    localparam logic [7:0] MASK_RST    = 8'hff;
    localparam logic [3:0] EN_RST      = 4'h4;
    localparam logic [3:0] AREA_RST    = 4'h0;
    localparam int CTRL_EN_LSB   = 0;
    localparam int CTRL_AREA_LSB = 4;
    localparam int STAT_SEL_LSB  = 0;
    localparam int MASK_A8_BIT   = 0;
    localparam int MASK_A14_BIT  = 1;
    localparam logic [23:0] DEF0_LO = 24'h007f00;
    localparam logic [23:0] DEF0_HI = 24'h007fff;
    localparam logic [23:0] DEF1_LO = 24'h000080;
    localparam logic [23:0] DEF1_HI = 24'h007fff;
    localparam logic [23:0] DEF2_LO = 24'h008000;
    localparam logic [23:0] DEF2_HI = 24'h3fffff;
    typedef enum logic [1:0] {
        KIND_CS0 = 2'b00,
        KIND_CS1 = 2'b01,
        KIND_CS2 = 2'b10,
        KIND_CS3 = 2'b11
    } csdec_kind_t;
endpackage : csdec_pkg

// [pkg/csdec_cfg_if.sv]
// start and mask contents shared by the register store and the decoders
// assumes the store drives every field from reset onward
interface csdec_cfg_if;
    logic [3:0][7:0] start;
    logic [3:0][7:0] mask;
    modport mem  (output start, output mask);
    modport user (input start, input mask);
endinterface : csdec_cfg_if

// [design/csdec_match.sv]
// address match of one select channel
// assumes the address is stable for the whole bus cycle
module csdec_match
    import csdec_pkg::*;
#(
    parameter csdec_kind_t KIND = KIND_CS0
) (
    input  wire logic [23:0] addr,   // bus address
    input  wire logic [7:0]  start,  // start value for A23..A16
    input  wire logic [7:0]  mask,   // mask register
    input  wire logic        area,   // 1: programmed area
    output logic             hit     // address lies in the area
);
    logic [15:0] eff_mask;
    logic        prog_hit;
    logic        def_hit;

    always_comb begin
        // bit n of eff_mask stands for address bit A(n+8)
        case (KIND)
            KIND_CS0: eff_mask = {3'b000, mask[7:2], {6{mask[MASK_A14_BIT]}},  // RL6 RL9
                                  mask[MASK_A8_BIT]};
            // channel 1 has no separate A15 mask bit: the group bit spans A15..A9
            KIND_CS1: eff_mask = {2'b00, mask[7:2], {7{mask[MASK_A14_BIT]}},  // RL8 RL9
                                  mask[MASK_A8_BIT]};
            KIND_CS2,
            KIND_CS3: eff_mask = {1'b0, mask, 7'h7f};  // RL8
            default:  eff_mask = 16'h0000;
        endcase
        // low start bits are hard zero; masked bits drop out of the compare
        prog_hit = (((addr[23:8] ^ {start, 8'h00}) & ~eff_mask)  // RL2 RL5 RL10
                    == 16'h0000);  // RL7 RL11 RL12
        case (KIND)
            KIND_CS0: def_hit = (addr >= DEF0_LO) && (addr <= DEF0_HI);
            KIND_CS1: def_hit = (addr >= DEF1_LO) && (addr <= DEF1_HI);
            KIND_CS2: def_hit = (addr >= DEF2_LO) && (addr <= DEF2_HI);
            default:  def_hit = 1'b0;
        endcase
        hit = area ? prog_hit : def_hit;  // RL14
    end
endmodule // csdec_match

// [design/csdec_regmem.sv]
// storage of the four start and four mask registers
// assumes read and write strobes never come together
module csdec_regmem
    import csdec_pkg::*;
(
    input  wire logic       clk,    // system clock
    input  wire logic       reset,  // async, active high
    input  wire logic [7:0] addr,   // register address
    input  wire logic [7:0] wdata,  // write data
    input  wire logic       wr,     // write strobe
    input  wire logic       rd,     // read strobe
    output logic [7:0]      rdata,  // read data, zero off this range
    csdec_cfg_if.mem        cfg     // contents to decoders
);
    typedef struct packed {
        logic [3:0][7:0] start;
        logic [3:0][7:0] mask;
        logic [7:0]      rdata;
    } csdec_mem_t;

    csdec_mem_t st;
    csdec_mem_t next_st;
    logic       in_range;
    logic [1:0] ch;
    logic       is_mask;

    // the eight registers sit on one aligned block of eight addresses
    assign in_range = (addr[7:3] == START0_OFS[7:3]);
    assign ch       = addr[2:1];
    assign is_mask  = (addr[0] == MASK0_OFS[0]);

    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;
        if (wr && in_range) begin
            if (is_mask) begin
                next_st.mask[ch] = wdata;
            end else begin
                next_st.start[ch] = wdata;  // RL4
            end
        end
        if (rd && in_range) begin
            next_st.rdata = is_mask ? st.mask[ch] : st.start[ch];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= {{NUM_CH{START_RST}}, {NUM_CH{MASK_RST}}, 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign rdata     = st.rdata;
    assign cfg.start = st.start;
    assign cfg.mask  = st.mask;
endmodule // csdec_regmem

// [design/csdec_top.sv]
// four-channel programmable chip select decoder
// assumes the register master follows the one-cycle strobe protocol
// and that bus address and bus-cycle flag are synchronous to CLK
module csdec_top
    import csdec_pkg::*;
(
    input  wire logic        CLK,            // system clock
    input  wire logic        RESET,          // async, active high
    input  wire logic [7:0]  REG_ADDR,       // register address
    input  wire logic [7:0]  REG_WDATA,      // register write data
    input  wire logic        REG_WR,         // write strobe
    input  wire logic        REG_RD,         // read strobe
    output logic      [7:0]  REG_RDATA,      // read data, cycle after strobe
    input  wire logic        BUS_CYCLE,      // a bus cycle is in progress
    input  wire logic [23:0] BUS_ADDR,       // bus address A23..A0
    output logic      [3:0]  SELECT_LINE_N   // select lines, active low
);
    import csdec_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------

    typedef struct packed {
        logic [3:0] en;
        logic [3:0] area;
        logic [7:0] rdata;
    } csdec_top_t;

    csdec_top_t  st;
    csdec_top_t  next_st;
    logic [7:0]  mem_rdata;
    logic [3:0]  hit;
    logic [3:0]  sel;

    csdec_cfg_if cfg ();

    // ------------------------------------------------------------
    // register store
    // ------------------------------------------------------------

    csdec_regmem u_mem (
        .clk   (CLK),
        .reset (RESET),
        .addr  (REG_ADDR),
        .wdata (REG_WDATA),
        .wr    (REG_WR),
        .rd    (REG_RD),
        .rdata (mem_rdata),
        .cfg   (cfg.mem)
    );

    // ------------------------------------------------------------
    // address decoders
    // ------------------------------------------------------------

    // each channel checks the address of every bus cycle
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch  // RL1
        csdec_match #(
            .KIND (csdec_kind_t'(i))
        ) u_match (
            .addr  (BUS_ADDR),
            .start (cfg.start[i]),
            .mask  (cfg.mask[i]),
            .area  (st.area[i]),
            .hit   (hit[i])
        );
    end

    // no flop on the path: the select must track the current address
    assign sel           = {4{BUS_CYCLE}} & st.en & hit;  // RL3 RL15
    assign SELECT_LINE_N = ~sel;

    // ------------------------------------------------------------
    // control and status registers
    // ------------------------------------------------------------

    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;
        if (REG_WR && (REG_ADDR == CTRL_OFS)) begin
            next_st.en   = REG_WDATA[CTRL_EN_LSB +: 4];
            next_st.area = REG_WDATA[CTRL_AREA_LSB +: 4];
        end
        if (REG_RD) begin
            case (REG_ADDR)
                CTRL_OFS: begin
                    next_st.rdata[CTRL_EN_LSB +: 4]   = st.en;
                    next_st.rdata[CTRL_AREA_LSB +: 4] = st.area;
                end
                STATUS_OFS: begin
                    next_st.rdata[STAT_SEL_LSB +: 4] = sel;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st <= {EN_RST, AREA_RST, 8'h00};
        end else begin
            st <= next_st;
        end
    end

    // only one of the two read registers is non-zero at a time
    assign REG_RDATA = st.rdata | mem_rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    logic [7:0] s0;
    logic [7:0] m0;
    logic [7:0] s1;
    logic [7:0] m1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] m3;
    logic       ch3_exp;

    assign s0 = cfg.start[0];
    assign m0 = cfg.mask[0];
    assign s1 = cfg.start[1];
    assign m1 = cfg.mask[1];
    assign s2 = cfg.start[2];
    assign s3 = cfg.start[3];
    assign m3 = cfg.mask[3];

    // independent reference for channel 3 with a masked start
    assign ch3_exp = BUS_CYCLE && st.en[3] && st.area[3]
                     && (((BUS_ADDR[23:16] ^ s3) & ~{1'b0, m3[7:1]}) == 8'h00)
                     && (!BUS_ADDR[15] || m3[0]);

    sequence wr_start0_s;
        REG_WR && (REG_ADDR == START0_OFS);
    endsequence

    sequence wr_mask3_s;
        REG_WR && (REG_ADDR == MASK3_OFS);
    endsequence

    sequence rd_mask1_s;
        REG_RD && (REG_ADDR == MASK1_OFS);
    endsequence

    sequence rd_status_s;
        REG_RD && (REG_ADDR == STATUS_OFS);
    endsequence

    sequence wr_ctrl_s;
        REG_WR && (REG_ADDR == CTRL_OFS);
    endsequence

    idle_lines_high_a: assert property (  // RL15
        !BUS_CYCLE |-> (SELECT_LINE_N == 4'hf))
        else $error("select low outside a bus cycle");

    disabled_line_high_a: assert property (  // RL3
        ((~SELECT_LINE_N) & ~st.en) == 4'h0)
        else $error("disabled channel drove its select");

    ch3_match_a: assert property (  // RL3
        (!SELECT_LINE_N[3] && st.area[3]) == ch3_exp)
        else $error("channel 3 select disagrees with its area");

    ch0_top_bits_a: assert property (  // RL6
        (!SELECT_LINE_N[0] && st.area[0])
        |-> (BUS_ADDR[23:21] == s0[7:5]))
        else $error("channel 0 selected with A23..A21 mismatch");

    ch0_a16_cmp_a: assert property (  // RL7
        (!SELECT_LINE_N[0] && st.area[0] && !m0[3])
        |-> (BUS_ADDR[16] == s0[0]))
        else $error("channel 0 selected with unmasked A16 mismatch");

    ch0_low_zero_a: assert property (  // RL5
        (!SELECT_LINE_N[0] && st.area[0] && !m0[MASK_A8_BIT])
        |-> !BUS_ADDR[8])
        else $error("channel 0 selected with A8 set while compared");

    ch1_group_a: assert property (  // RL9
        (!SELECT_LINE_N[1] && st.area[1] && !m1[MASK_A14_BIT])
        |-> (BUS_ADDR[15:9] == 7'h00))
        else $error("channel 1 grouped bits not compared as zero");

    ch1_a21_a: assert property (  // RL8
        (!SELECT_LINE_N[1] && st.area[1] && !m1[7])
        |-> (BUS_ADDR[23:21] == s1[7:5]))
        else $error("channel 1 upper bits mismatch");

    ch2_top_bit_a: assert property (  // RL8
        (!SELECT_LINE_N[2] && st.area[2])
        |-> (BUS_ADDR[23] == s2[7]))
        else $error("channel 2 selected with A23 mismatch");

    ch1_default_a: assert property (  // RL14
        (!SELECT_LINE_N[1] && !st.area[1])
        |-> (BUS_ADDR >= DEF1_LO) && (BUS_ADDR <= DEF1_HI))
        else $error("channel 1 default area violated");

    start_write_a: assert property (  // RL4
        wr_start0_s |=> (s0 == $past(REG_WDATA))
                        ##1 ((s0 == $past(REG_WDATA, 2))
                             || $past(REG_WR && (REG_ADDR == START0_OFS))))
        else $error("start register did not take the write");

    mask_write_a: assert property (  // RL2
        wr_mask3_s |=> (m3 == $past(REG_WDATA)))
        else $error("mask register did not take the write");

    mask_read_a: assert property (  // RL2
        rd_mask1_s |=> (REG_RDATA == $past(m1)))
        else $error("mask read data wrong");

    status_read_a: assert property (  // RL15
        rd_status_s |=> (REG_RDATA == {4'h0, $past(sel)}))
        else $error("status read data wrong");

    ctrl_write_a: assert property (  // RL14
        wr_ctrl_s |=> (st.area == $past(REG_WDATA[7:4]))
                      ##1 (REG_RDATA == 8'h00 || $past(REG_RD)))
        else $error("control write not taken");

endmodule // csdec_top

// [test/csdec_mem_model.sv]
// stand-in for the memories and devices hanging on the select lines
// assumes select lines are active low and sampled on the system clock
module csdec_mem_model (
    input  wire logic       clk,    // system clock
    input  wire logic       reset,  // clears the access record
    input  wire logic [3:0] sel_n,  // select lines, active low
    output logic      [3:0] seen    // device selected since reset
);
    timeunit 1ns;
    timeprecision 1ps;

    // a device only notices being selected at a clock edge,
    // so a glitch between edges is not counted as an access
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seen <= 4'h0;
        end else begin
            seen <= seen | ~sel_n;
        end
    end
endmodule // csdec_mem_model

// [test/testbench.sv]
// self-checking bench of the chip select decoder
// assumes csdec_top and csdec_mem_model are compiled before it
module testbench
    import csdec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset, reg_wr, reg_rd, bus_cycle;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, ctrl;
    logic [23:0] bus_addr;
    logic [3:0]  select_line_n, seen;
    logic [7:0]  st [4];
    logic [7:0]  mk [4];
    int          errors, checked;
    logic [23:0] tbl [15] = '{24'h030000, 24'h040000, 24'h018000, 24'h010100, 24'h408000,
        24'h410000, 24'hc00000, 24'h808000, 24'h800000, 24'hff0000, 24'h1f0000,
        24'h000010, 24'h000100, 24'h010000, 24'h000080};

    csdec_top dut_u (.CLK(clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BUS_CYCLE(bus_cycle),
        .BUS_ADDR(bus_addr), .SELECT_LINE_N(select_line_n));
    csdec_mem_model mem_u (.clk(clk), .reset(reset), .sel_n(select_line_n), .seen(seen));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // reference decode and port tasks
    // ------------------------------------------------------------
    function automatic logic [3:0] exp_sel(input logic [23:0] a);
        logic [15:0] em;
        logic [3:0]  r;
        logic        hit;
        r = 4'hf;
        for (int i = 0; i < 4; i++) begin
            case (i)
                0: em = {3'b000, mk[0][7:2], {6{mk[0][1]}}, mk[0][0]};
                1: em = {2'b00, mk[1][7:2], {7{mk[1][1]}}, mk[1][0]};
                default: em = {1'b0, mk[i], 7'h7f};
            endcase
            if (ctrl[CTRL_AREA_LSB + i]) begin
                hit = ((a[23:8] ^ {st[i], 8'h00}) & ~em) == 16'h0000;
            end else begin
                hit = (i == 0) ? (a >= DEF0_LO && a <= DEF0_HI) :
                      (i == 1) ? (a >= DEF1_LO && a <= DEF1_HI) :
                      (i == 2) ? (a >= DEF2_LO && a <= DEF2_HI) : 1'b0;
            end
            if (bus_cycle && ctrl[CTRL_EN_LSB + i] && hit) r[i] = 1'b0;
        end
        return r;
    endfunction

    task automatic cmp_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_sel(input string n, input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // the shadow copy is updated at the edge where the write lands
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a[7:3] == 5'h08) begin
            if (a[0]) mk[a[2:1]] = v;
            else st[a[2:1]] = v;
        end
        if (a == CTRL_OFS) ctrl = v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        cmp_reg($sformatf("reg %h", a), e, d);
    endtask

    // mask goes in before start, as software is told to do
    task automatic load(input logic [63:0] c);
        for (int i = 0; i < 4; i++) begin
            wr(8'(MASK0_OFS + 2 * i), c[63 - 16 * i -: 8]);
            wr(8'(START0_OFS + 2 * i), c[55 - 16 * i -: 8]);
        end
    endtask

    task automatic sweep;
        for (int i = 0; i < 15; i++) begin
            @(posedge clk);
            bus_addr  <= tbl[i];
            bus_cycle <= 1'b1;
            @(posedge clk);
            #1;
            cmp_sel($sformatf("sel at %h", tbl[i]), exp_sel(tbl[i]), select_line_n);
        end
        @(posedge clk);
        bus_cycle <= 1'b0;
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        bus_cycle = 1'b0;
        bus_addr = 24'h000000;
        errors = 0;
        checked = 0;
        st = '{default: START_RST};
        mk = '{default: MASK_RST};
        ctrl = {AREA_RST, EN_RST};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) chk(8'(8'h40 + i), i[0] ? MASK_RST : START_RST);
        chk(CTRL_OFS, ctrl);
        wr(8'h50, 8'h5a);
        chk(8'h50, 8'h00);
        sweep;
        @(posedge clk);
        bus_addr <= 24'h010000;
        @(posedge clk);
        #1;
        cmp_sel("idle bus", 4'hf, select_line_n);
        wr(CTRL_OFS, 8'h0f);
        sweep;
        load(64'h0f03_0201_0140_80c0);
        wr(CTRL_OFS, 8'hff);
        sweep;
        for (int i = 0; i < 8; i++) chk(8'(8'h40 + i), i[0] ? mk[i / 2] : st[i / 2]);
        load(64'hffff_0000_ff00_0001);
        sweep;
        wr(CTRL_OFS, 8'hf0);
        sweep;
        wr(CTRL_OFS, 8'h5f);
        sweep;
        @(posedge clk);
        bus_addr  <= 24'h408000;
        bus_cycle <= 1'b1;
        @(posedge clk);
        chk(STATUS_OFS, {4'h0, ~exp_sel(24'h408000)});
        @(posedge clk);
        bus_cycle <= 1'b0;
        cmp_reg("devices selected", 8'h0f, {4'h0, seen});
        end_of_test;
    end

    // cuts a hang short; the whole run needs far fewer cycles
    initial begin
        #100000;
        errors++;
        end_of_test;
    end
endmodule // testbench
